//--- sac_top.sv
// Converter control: gating, channel routing, triggers, result and flags
//
// Functional notes
// - Clock gate bit comes up set.
// - Cleared gate bit stops the module's clock.
// - Codes 00000..01011 route pins AD0..AD11.
// - Reserved codes still convert, undefined result.
// - Codes select internal supplies, sensor, bandgap, references.
// - Four conversion clock sources are selectable.
// - Counter match starts conversion when hardware-triggered.
// - Match triggers regardless of counter interrupt enable.
// - Hardware trigger works in run, wait, deep stop.
// - Linear successive approximation gives twelve bits.
// - Result right-justified as 12, 10 or 8 bits.
// - Single and continuous modes; single returns idle.
// - Optional compare, less-than or greater-or-equal.
// - Completion flag and interrupt request provided.
// - Converter keeps running in wait and deep stop.
// - Sample time and speed/power are configurable.
// - Up to 19 inputs via channel select.
// - Control write aborts and restarts, or arms when hardware-triggered, unless all ones.
// - All-ones select powers off, ends continuous cleanly.
// - Flag clears on control write or low read.
// - Interrupt asserts while flag set and enabled.
`timescale 1ns/100ps
module sac_top (
   input  wire logic                      clk,
   input  wire logic                      rst_n,
   input  wire logic                      clock_gate_wr,
   input  wire logic                      clock_gate_wdata,
   input  wire logic                      sc1_wr,
   input  wire sac_pkg::sac_sc1_t         sc1_wdata,
   input  wire sac_pkg::sac_cfg_t         cfg,
   input  wire logic                      result_low_read,
   input  wire logic [sac_pkg::RTC_W-1:0] rtc_count_value,
   input  wire logic [sac_pkg::RTC_W-1:0] rtc_modulo_value,
   input  wire logic                      local_async_clock,
   input  wire logic                      alternate_clock,
   input  wire logic                      cmp_in,
   output logic                           module_clock_en,
   output sac_pkg::sac_sc1_t              sc1_rdata,
   output logic                           conversion_done_flag,
   output logic                           irq,
   output logic                           conv_active,
   output logic                           sar_power_on,
   output sac_pkg::sac_route_t            route,
   output logic      [sac_pkg::RES_W-1:0] dac_code,
   output logic      [sac_pkg::RES_W-1:0] result
);
   import sac_pkg::*;

   typedef struct packed {
      logic             gate;
      sac_sc1_t         sc1;
      logic             done;
      logic             irq;
      logic             armed;
      logic             match_q;
      logic             div;
      logic             slow;
      logic [RES_W-1:0] result;
      sac_route_t       route;
   } sac_top_s_t;

   sac_top_s_t s;
   sac_top_s_t next_s;

   logic             start;
   logic             abort;
   logic             tick;
   logic             raw_tick;
   logic             match;
   logic             hw_evt;
   logic             pass;
   logic             set_done;
   logic             clr_done;
   logic [4:0]       sample_len;
   logic [RES_W-1:0] fres;
   logic             sar_done;
   logic             sar_busy;
   logic [RES_W-1:0] sar_result;

   function automatic sac_route_t route_of(input logic [CH_W-1:0] ch);
      sac_route_t r;
      r.code = ch;
      r.pin_en = (ch <= CH_PIN_LAST);
      r.internal_en = (ch >= CH_INT_FIRST) && (ch <= CH_INT_LAST);
      r.ref_en = (ch == CH_VREFH) || (ch == CH_VREFL);
      return r;
   endfunction

   // Reserved codes leave every path off yet the search still runs
   sac_sar u_sar (
      .clk        (clk),
      .rst_n      (rst_n),
      .start      (start),
      .abort      (abort),
      .tick       (tick),
      .sample_len (sample_len),
      .cmp_in     (cmp_in),
      .dac_code   (dac_code),
      .busy       (sar_busy),
      .done       (sar_done),
      .result     (sar_result)
   );

   assign sample_len = cfg.long_sample ? SAMPLE_LONG : SAMPLE_SHORT;

   // Counter match as a one-cycle event; no counter interrupt gating
   assign match  = (rtc_count_value == rtc_modulo_value);
   assign hw_evt = match && !s.match_q;

   always_comb begin
      unique case (cfg.clk_src)
         SAC_CK_BUS:      raw_tick = 1'b1;
         SAC_CK_BUS_DIV2: raw_tick = s.div;
         SAC_CK_LOCAL:    raw_tick = local_async_clock;
         SAC_CK_ALT:      raw_tick = alternate_clock;
      endcase
   end

   // Low power halves the step rate, trading speed for current
   assign tick = s.gate && raw_tick && (!cfg.low_power || s.slow);

   always_comb begin
      unique case (cfg.fmt)
         SAC_FMT_8:  fres = {4'h0, sar_result[11:4]};
         SAC_FMT_10: fres = {2'h0, sar_result[11:2]};
         default:    fres = sar_result;
      endcase
   end

   always_comb begin
      if (!cfg.compare_function_enable) begin
         pass = 1'b1;
      end else if (cfg.compare_greater_equal) begin
         pass = (fres >= cfg.compare_value);
      end else begin
         pass = (fres < cfg.compare_value);
      end
   end

   assign set_done = s.gate && sar_done && pass;
   assign clr_done = s.gate && (sc1_wr || result_low_read);

   always_comb begin
      next_s = s;
      start = 1'b0;
      abort = 1'b0;
      next_s.match_q = match;
      if (clock_gate_wr) begin
         next_s.gate = clock_gate_wdata;
      end
      // Nothing advances without the module clock, so no trigger or write lands
      if (s.gate) begin
         next_s.div = !s.div;
         if (raw_tick) begin
            next_s.slow = !s.slow;
         end
         // A result landing with a control write is kept, as its flag is
         if (sar_done && pass) begin
            next_s.result = fres;
         end
         if (sc1_wr) begin
            next_s.sc1 = sc1_wdata;
            next_s.route = route_of(sc1_wdata.channel_select);
            next_s.armed = 1'b0;
            abort = 1'b1;
            if (sc1_wdata.channel_select != CH_OFF) begin
               if (cfg.hw_trigger_select) begin
                  next_s.armed = 1'b1;
               end else begin
                  start = 1'b1;
               end
            end
         end else begin
            if (s.armed && hw_evt && cfg.hw_trigger_select) begin
               start = 1'b1;
               next_s.armed = 1'b0;
            end
            if (sar_done) begin
               if (s.sc1.continuous_conv_enable) begin
                  if (cfg.hw_trigger_select) begin
                     next_s.armed = 1'b1;
                  end else begin
                     start = 1'b1;
                  end
               end
            end
         end
      end
      // A completion in the clearing cycle is kept
      next_s.done = set_done || (s.done && !clr_done);
      next_s.irq = next_s.done && next_s.sc1.done_irq_enable;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s <= '{gate: 1'b1,
                sc1: '{done_irq_enable: 1'b0, continuous_conv_enable: 1'b0,
                       channel_select: CH_OFF},
                done: 1'b0, irq: 1'b0, armed: 1'b0, match_q: 1'b0,
                div: 1'b0, slow: 1'b0, result: 12'h000,
                route: '{pin_en: 1'b0, internal_en: 1'b0, ref_en: 1'b0,
                         code: CH_OFF}};
      end else begin
         s <= next_s;
      end
   end

   assign module_clock_en      = s.gate;
   assign sc1_rdata            = s.sc1;
   assign conversion_done_flag = s.done;
   assign irq                  = s.irq;
   assign conv_active          = sar_busy;
   assign sar_power_on         = (s.sc1.channel_select != CH_OFF);
   assign route                = s.route;
   assign result               = s.result;

   AST_GATE_RESET: assert property (
      @(posedge clk) disable iff (!rst_n)
      $past(!rst_n) |-> module_clock_en)
      else $error("clock gate not set after reset");

   AST_GATE_CLEAR: assert property (
      @(posedge clk) disable iff (!rst_n)
      clock_gate_wr && !clock_gate_wdata |=> !module_clock_en)
      else $error("clock gate did not clear");

   AST_GATE_FREEZE: assert property (
      @(posedge clk) disable iff (!rst_n)
      !module_clock_en && !clock_gate_wr |=> $stable(result) && $stable(conv_active))
      else $error("block advanced while clock gated");

   AST_PIN_ROUTE: assert property (
      @(posedge clk) disable iff (!rst_n)
      module_clock_en && sc1_wr && sc1_wdata.channel_select <= CH_PIN_LAST
      |=> route.pin_en && !route.internal_en && route.code == $past(sc1_wdata.channel_select))
      else $error("pin channel not routed");

   AST_RESERVED_RUNS: assert property (
      @(posedge clk) disable iff (!rst_n)
      module_clock_en && sc1_wr && !cfg.hw_trigger_select
      && sc1_wdata.channel_select == 5'h1c
      |=> conv_active && !route.pin_en && !route.internal_en && !route.ref_en)
      else $error("reserved channel did not convert");

   AST_INTERNAL_SRC: assert property (
      @(posedge clk) disable iff (!rst_n)
      route.internal_en |-> route.code >= CH_INT_FIRST && route.code <= CH_INT_LAST
      && !route.pin_en)
      else $error("internal source decode wrong");

   AST_HW_TRIGGER: assert property (
      @(posedge clk) disable iff (!rst_n)
      module_clock_en && !sc1_wr && s.armed && cfg.hw_trigger_select && hw_evt
      |=> conv_active ##1 !s.armed || sc1_wr)
      else $error("counter match did not start conversion");

   AST_SINGLE_IDLE: assert property (
      @(posedge clk) disable iff (!rst_n)
      sar_done && !s.sc1.continuous_conv_enable && !sc1_wr && !start
      |=> !conv_active)
      else $error("single conversion did not return idle");

   AST_COMPARE_HOLD: assert property (
      @(posedge clk) disable iff (!rst_n)
      module_clock_en && sar_done && !pass
      |=> $stable(result) && (conversion_done_flag == $past(s.done && !clr_done)))
      else $error("failed compare changed result or flag");

   AST_OFF_STOP: assert property (
      @(posedge clk) disable iff (!rst_n)
      module_clock_en && sc1_wr && sc1_wdata.channel_select == CH_OFF
      |=> !conv_active && !sar_power_on)
      else $error("all-ones select did not stop converter");

   AST_DONE_CLEAR: assert property (
      @(posedge clk) disable iff (!rst_n)
      clr_done && !set_done |=> !conversion_done_flag)
      else $error("completion flag not cleared");

   AST_DONE_SET_WINS: assert property (
      @(posedge clk) disable iff (!rst_n)
      set_done |=> conversion_done_flag)
      else $error("completion lost");

   AST_IRQ: assert property (
      @(posedge clk) disable iff (!rst_n)
      $rose(conversion_done_flag) && sc1_rdata.done_irq_enable |-> irq)
      else $error("interrupt missing on completion");

   AST_GATE_WRITE_IGNORED: assert property (
      @(posedge clk) disable iff (!rst_n)
      !module_clock_en && sc1_wr |=> $stable(sc1_rdata) && $stable(route))
      else $error("control write taken while clock gated");

   AST_REF_ROUTE: assert property (
      @(posedge clk) disable iff (!rst_n)
      module_clock_en && sc1_wr
      && (sc1_wdata.channel_select == CH_VREFH || sc1_wdata.channel_select == CH_VREFL)
      |=> route.ref_en && !route.pin_en && !route.internal_en)
      else $error("reference channel not routed");

   AST_SW_START: assert property (
      @(posedge clk) disable iff (!rst_n)
      module_clock_en && sc1_wr && !cfg.hw_trigger_select
      && sc1_wdata.channel_select != CH_OFF |=> conv_active)
      else $error("control write did not start conversion");

   AST_WRITE_READBACK: assert property (
      @(posedge clk) disable iff (!rst_n)
      module_clock_en && sc1_wr |=> sc1_rdata == $past(sc1_wdata))
      else $error("control write not held");

   AST_ARM_WAIT: assert property (
      @(posedge clk) disable iff (!rst_n)
      module_clock_en && sc1_wr && cfg.hw_trigger_select |=> !conv_active)
      else $error("armed write started without a match");

   AST_FMT_NARROW: assert property (
      @(posedge clk) disable iff (!rst_n)
      set_done && cfg.fmt != SAC_FMT_12
      |=> result[RES_W-1:RES_W-2] == 2'h0)
      else $error("narrow result not right-justified");

   AST_FLAG_FROM_DONE: assert property (
      @(posedge clk) disable iff (!rst_n)
      $rose(conversion_done_flag) |-> $past(set_done))
      else $error("flag set without a completion");

   AST_IRQ_LEVEL: assert property (
      @(posedge clk) disable iff (!rst_n)
      irq == (conversion_done_flag && sc1_rdata.done_irq_enable))
      else $error("interrupt does not follow flag and enable");

   AST_CONT_RESTART: assert property (
      @(posedge clk) disable iff (!rst_n)
      module_clock_en && sar_done && s.sc1.continuous_conv_enable
      && !cfg.hw_trigger_select && !sc1_wr |=> conv_active)
      else $error("continuous conversion did not restart");

   AST_OFF_QUIET: assert property (
      @(posedge clk) disable iff (!rst_n)
      !sar_power_on && !sc1_wr |=> !conv_active)
      else $error("converter ran while powered off");

endmodule // sac_top

//--- sac_pkg.sv
// Shared constants and types for the converter control block
package sac_pkg;

   localparam int          RES_W        = 12;
   localparam int          CH_W         = 5;
   localparam int          RTC_W        = 16;
   localparam logic [3:0]  RES_MSB      = 4'hb;
   localparam logic [11:0] SAR_TRIAL    = 12'h800;
   localparam logic [4:0]  CH_PIN_LAST  = 5'h0b;
   localparam logic [4:0]  CH_INT_FIRST = 5'h17;
   localparam logic [4:0]  CH_INT_LAST  = 5'h1b;
   localparam logic [4:0]  CH_VREFH     = 5'h1d;
   localparam logic [4:0]  CH_VREFL     = 5'h1e;
   localparam logic [4:0]  CH_OFF       = 5'h1f;
   localparam logic [4:0]  SAMPLE_SHORT = 5'h03;
   localparam logic [4:0]  SAMPLE_LONG  = 5'h13;

   typedef enum logic [1:0] {
      SAC_CK_BUS, SAC_CK_BUS_DIV2, SAC_CK_LOCAL, SAC_CK_ALT
   } sac_clk_src_t;

   typedef enum logic [1:0] {
      SAC_FMT_8, SAC_FMT_10, SAC_FMT_12
   } sac_fmt_t;

   typedef enum logic [1:0] {
      SAC_IDLE, SAC_SAMPLE, SAC_CONVERT
   } sac_sar_st_t;

   typedef struct packed {
      logic            done_irq_enable;
      logic            continuous_conv_enable;
      logic [CH_W-1:0] channel_select;
   } sac_sc1_t;

   typedef struct packed {
      logic             hw_trigger_select;
      logic             compare_function_enable;
      logic             compare_greater_equal;
      logic [RES_W-1:0] compare_value;
      sac_fmt_t         fmt;
      sac_clk_src_t     clk_src;
      logic             long_sample;
      logic             low_power;
   } sac_cfg_t;

   typedef struct packed {
      logic            pin_en;
      logic            internal_en;
      logic            ref_en;
      logic [CH_W-1:0] code;
   } sac_route_t;

   typedef struct packed {
      sac_sar_st_t      st;
      logic [4:0]       cnt;
      logic [3:0]       bitx;
      logic [RES_W-1:0] acc;
      logic             done;
      logic [RES_W-1:0] result;
   } sac_sar_s_t;

endpackage

//--- sac_sar.sv
// Successive approximation search engine with sample phase
`timescale 1ns/100ps
module sac_sar (
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   input  wire logic                     start,
   input  wire logic                     abort,
   input  wire logic                     tick,
   input  wire logic [4:0]               sample_len,
   input  wire logic                     cmp_in,
   output logic      [sac_pkg::RES_W-1:0] dac_code,
   output logic                          busy,
   output logic                          done,
   output logic      [sac_pkg::RES_W-1:0] result
);
   import sac_pkg::*;

   sac_sar_s_t s;
   sac_sar_s_t next_s;

   always_comb begin
      next_s = s;
      next_s.done = 1'b0;
      // A start also aborts whatever is running
      if (start) begin
         next_s.st = SAC_SAMPLE;
         next_s.cnt = sample_len;
         next_s.acc = SAR_TRIAL;
         next_s.bitx = RES_MSB;
      end else if (abort) begin
         next_s.st = SAC_IDLE;
      end else if (tick) begin
         unique case (s.st)
            SAC_IDLE: begin
            end
            SAC_SAMPLE: begin
               if (s.cnt == 5'h00) begin
                  next_s.st = SAC_CONVERT;
               end else begin
                  next_s.cnt = 5'(s.cnt - 5'h01);
               end
            end
            SAC_CONVERT: begin
               next_s.acc[s.bitx] = cmp_in;
               if (s.bitx == 4'h0) begin
                  next_s.st = SAC_IDLE;
                  next_s.done = 1'b1;
                  next_s.result = next_s.acc;
               end else begin
                  next_s.acc[4'(s.bitx - 4'h1)] = 1'b1;
                  next_s.bitx = 4'(s.bitx - 4'h1);
               end
            end
            default: next_s.st = SAC_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s <= '{st: SAC_IDLE, cnt: 5'h00, bitx: 4'h0, acc: 12'h000,
                done: 1'b0, result: 12'h000};
      end else begin
         s <= next_s;
      end
   end

   assign dac_code = s.acc;
   assign busy     = (s.st != SAC_IDLE);
   assign done     = s.done;
   assign result   = s.result;

endmodule // sac_sar

//--- sac_afe_model.sv
// Behavioural analog front end: one level per channel and the comparator
`timescale 1ns/100ps
module sac_afe_model
   import sac_pkg::*;
#(
   parameter logic [11:0] BASE = 12'h0a5,
   parameter logic [11:0] STEP = 12'h07b
) (
   input  wire logic                 clk,
   input  wire sac_pkg::sac_route_t  route,
   input  wire logic [RES_W-1:0]     dac_code,
   output logic                      cmp_in
);
   logic             wob = 1'b0;
   logic [RES_W-1:0] level;

   // An unrouted input floats: toggle so a stale level never looks valid
   always @(posedge clk) begin
      wob <= ~wob;
   end

   always_comb begin
      level = BASE + STEP * {7'h00, route.code};
      if (route.pin_en || route.internal_en || route.ref_en) begin
         cmp_in = (level >= dac_code);
      end else begin
         cmp_in = wob;
      end
   end
endmodule // sac_afe_model

//--- sac_top_tb_top.sv
// Self-checking bench for the converter control block
`timescale 1ns/100ps
module sac_top_tb_top;
   import sac_pkg::*;
   localparam logic [11:0] BASE = 12'h0a5;
   localparam logic [11:0] STEP = 12'h07b;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        clock_gate_wr = 1'b0;
   logic        clock_gate_wdata = 1'b1;
   logic        sc1_wr = 1'b0;
   sac_sc1_t    sc1_wdata = '1;
   sac_cfg_t    cfg = '0;
   logic        result_low_read = 1'b0;
   logic [15:0] rtc_count_value = 16'h0000;
   logic [15:0] rtc_modulo_value = 16'h0040;
   logic        local_async_clock = 1'b0;
   logic        alternate_clock = 1'b0;
   logic [1:0]  pdiv = 2'h0;
   logic        cmp_in, module_clock_en, flag, irq, conv_active, sar_power_on;
   sac_sc1_t    sc1_rdata;
   sac_route_t  route;
   logic [11:0] dac_code, result;
   int          errors = 0;
   int          comparisons = 0;
   int          n, c;

   always #20 clk = ~clk;

   // Slow step sources, one pulse every four cycles each
   always @(negedge clk) begin
      pdiv <= pdiv + 2'h1;
      local_async_clock <= (pdiv == 2'h0);
      alternate_clock <= (pdiv == 2'h1);
   end

   sac_top dut_u (.clk(clk), .rst_n(rst_n), .clock_gate_wr(clock_gate_wr),
      .clock_gate_wdata(clock_gate_wdata), .sc1_wr(sc1_wr), .sc1_wdata(sc1_wdata),
      .cfg(cfg), .result_low_read(result_low_read), .rtc_count_value(rtc_count_value),
      .rtc_modulo_value(rtc_modulo_value), .local_async_clock(local_async_clock),
      .alternate_clock(alternate_clock), .cmp_in(cmp_in), .module_clock_en(module_clock_en),
      .sc1_rdata(sc1_rdata), .conversion_done_flag(flag), .irq(irq),
      .conv_active(conv_active), .sar_power_on(sar_power_on), .route(route),
      .dac_code(dac_code), .result(result));

   sac_afe_model #(.BASE(BASE), .STEP(STEP)) afe_u (.clk(clk), .route(route),
      .dac_code(dac_code), .cmp_in(cmp_in));

   function automatic logic [11:0] expv(input logic [4:0] ch);
      logic [11:0] v;
      v = BASE + STEP * {7'h00, ch};
      case (cfg.fmt)
         SAC_FMT_10: return v >> 2;
         SAC_FMT_8: return v >> 4;
         default: return v;
      endcase
   endfunction

   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("Error t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic sc1_write(input logic ie, input logic co, input logic [4:0] ch);
      sc1_wr = 1'b1;
      sc1_wdata = '{ie, co, ch};
      @(negedge clk);
      sc1_wr = 1'b0;
   endtask

   task automatic gate_write(input logic v);
      clock_gate_wr = 1'b1;
      clock_gate_wdata = v;
      @(negedge clk);
      clock_gate_wr = 1'b0;
      @(negedge clk);
   endtask

   task automatic read_low();
      result_low_read = 1'b1;
      @(negedge clk);
      result_low_read = 1'b0;
      @(negedge clk);
   endtask

   // Counts edges from the write edge until the flag shows
   task automatic wait_flag(output int k);
      k = 0;
      while (flag !== 1'b1 && k < 400) begin
         @(negedge clk);
         k++;
      end
   endtask

   task automatic run_conv(input logic ie, input logic [4:0] ch, input int lo, input int hi);
      sc1_write(ie, 1'b0, ch);
      wait_flag(n);
      check(16'(n >= lo && n <= hi), 16'h1, "latency");
      check(16'(result), 16'(expv(ch)), "result");
      check(16'(irq), 16'(ie), "irq");
      @(negedge clk);
      check(16'(conv_active), 16'h0, "idle after single");
   endtask

   task automatic summarize();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   initial begin
      #(40 * 30000);
      errors++;
      $display("Error t=%0t watchdog expired", $time);
      summarize();
   end

   initial begin
      cfg.fmt = SAC_FMT_12;
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      check(16'(module_clock_en), 16'h1, "gate at reset");
      check(16'(sar_power_on), 16'h0, "power at reset");
      check(16'(flag), 16'h0, "flag at reset");
      $display("test reset finished");
      for (c = 0; c < 3; c++) begin
         cfg.fmt = sac_fmt_t'(c);
         run_conv(1'b1, 5'h03, 17, 17);
      end
      read_low();
      check(16'(flag), 16'h0, "flag after low read");
      check(16'(irq), 16'h0, "irq after low read");
      $display("test single finished");
      for (c = 0; c < 32; c++) begin
         sc1_write(1'b0, 1'b0, 5'(c));
         @(negedge clk);
         check(16'(route.pin_en), 16'(c <= 11), "pin route");
         check(16'(route.internal_en), 16'(c >= 23 && c <= 27), "internal");
         check(16'(route.ref_en), 16'(c == 29 || c == 30), "reference");
         check(16'(conv_active), 16'(c != 31), "converting");
         check(16'(sar_power_on), 16'(c != 31), "powered");
         check(16'(sc1_rdata.channel_select), 16'(c), "readback");
         check(16'(route.code), 16'(c), "route code");
         check(16'(dac_code), 16'h0800, "first trial");
      end
      run_conv(1'b0, 5'h1b, 17, 17);
      run_conv(1'b1, 5'h1d, 17, 17);
      $display("test routing finished");
      sc1_write(1'b1, 1'b0, 5'h02);
      @(negedge clk);
      check(16'(flag), 16'h0, "flag after write");
      repeat (6) @(negedge clk);
      run_conv(1'b1, 5'h06, 17, 17);
      $display("test abort finished");
      cfg.long_sample = 1'b1;
      run_conv(1'b1, 5'h03, 33, 33);
      cfg.long_sample = 1'b0;
      cfg.low_power = 1'b1;
      run_conv(1'b1, 5'h03, 18, 300);
      cfg.low_power = 1'b0;
      for (c = 1; c < 4; c++) begin
         cfg.clk_src = sac_clk_src_t'(c);
         run_conv(1'b1, 5'h03, 18, 300);
      end
      cfg.clk_src = SAC_CK_BUS;
      $display("test clocking finished");
      cfg.compare_function_enable = 1'b1;
      cfg.compare_value = expv(5'h03) + 12'h001;
      run_conv(1'b1, 5'h03, 17, 17);
      cfg.compare_greater_equal = 1'b1;
      sc1_write(1'b1, 1'b0, 5'h03);
      repeat (40) @(negedge clk);
      check(16'(flag), 16'h0, "compare false");
      cfg.compare_value = expv(5'h03);
      run_conv(1'b1, 5'h03, 17, 17);
      cfg.compare_function_enable = 1'b0;
      $display("test compare finished");
      sc1_write(1'b0, 1'b1, 5'h04);
      wait_flag(n);
      check(16'(result), 16'(expv(5'h04)), "continuous result");
      read_low();
      wait_flag(n);
      check(16'(n >= 1 && n <= 18), 16'h1, "continuous again");
      sc1_write(1'b0, 1'b0, 5'h1f);
      @(negedge clk);
      check(16'(conv_active), 16'h0, "stopped");
      repeat (40) @(negedge clk);
      check(16'(flag), 16'h0, "no extra conversion");
      $display("test continuous finished");
      cfg.hw_trigger_select = 1'b1;
      sc1_write(1'b0, 1'b0, 5'h03);
      repeat (5) @(negedge clk);
      check(16'(conv_active), 16'h0, "armed only");
      rtc_count_value = 16'h0040;
      wait_flag(n);
      check(16'(n >= 17 && n <= 19), 16'h1, "trigger latency");
      check(16'(result), 16'(expv(5'h03)), "trigger result");
      rtc_count_value = 16'h0000;
      cfg.hw_trigger_select = 1'b0;
      $display("test trigger finished");
      // Gate off in mid-conversion: the search must freeze on its first trial
      sc1_write(1'b0, 1'b0, 5'h03);
      repeat (3) @(negedge clk);
      gate_write(1'b0);
      check(16'(module_clock_en), 16'h0, "gate off");
      sc1_write(1'b0, 1'b0, 5'h05);
      repeat (30) @(negedge clk);
      check(16'(conv_active), 16'h1, "frozen");
      check(16'(dac_code), 16'h0800, "trial held");
      check(16'(flag), 16'h0, "no completion while gated");
      check(16'(sc1_rdata.channel_select), 16'h0003, "write ignored");
      gate_write(1'b1);
      check(16'(module_clock_en), 16'h1, "gate on");
      run_conv(1'b1, 5'h05, 17, 17);
      $display("test gating finished");
      gate_write(1'b0);
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      check(16'(module_clock_en), 16'h1, "gate after reset");
      check(16'(flag), 16'h0, "flag after reset");
      check(16'(irq), 16'h0, "irq after reset");
      check(16'(sar_power_on), 16'h0, "power after reset");
      run_conv(1'b1, 5'h05, 17, 17);
      $display("test reset again finished");
      summarize();
   end
endmodule // sac_top_tb_top
